// File: design/hs_pkg.sv
// shared constants and types for the hot swap fault sequencer
package hs_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int INS_DELAY_MS = 32;
    localparam int INS_DELAY_CYC = INS_DELAY_MS * (CLK_HZ / 1000);
    localparam int PG_RISE_MS = 1;
    localparam int PG_RISE_CYC = PG_RISE_MS * (CLK_HZ / 1000);
    localparam int PG_FALL_MS = 32;
    localparam int PG_FALL_CYC = PG_FALL_MS * (CLK_HZ / 1000);
    localparam int COOL_CYCLES = 63;
    localparam int CNT_W = 24;
    localparam logic [5:0] COOL_RESET = 6'h00;
    localparam logic [1:0] LIMIT_SELECT_PIN_FLOAT = 2'h0;
    localparam logic [1:0] LIMIT_SELECT_PIN_R190K = 2'h1;
    localparam logic [1:0] LIMIT_SELECT_PIN_R70K = 2'h2;
    localparam logic [1:0] LIMIT_SELECT_PIN_GND = 2'h3;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_INSERT,
        ST_START,
        ST_NORMAL
    } hs_state_e;

    typedef enum logic [1:0] {
        TMR_IDLE,
        TMR_DISCH,
        TMR_CHARGE,
        TMR_FINAL
    } tmr_state_e;

    typedef enum logic [1:0] {
        TI_SINK2,
        TI_SRC10,
        TI_SRC50,
        TI_FULL_DISCH
    } tmr_cur_e;
endpackage

// File: design/hs_sync_if.sv
// synchronised comparator levels passed from the input stage to the controller
`timescale 1ns/1ps
interface hs_sync_if;
    logic vin_ok;
    logic vcc_ok;
    logic uv_en;
    logic ft_cmp;
    logic drain_cl_hi;
    logic drain_tmr_hi;
    logic drain_pg_lo;
    logic in_limit;
    logic gate_above_th;
    logic gate_full;
    logic tmr_at_15;
    logic tmr_at_075;
    logic tmr_at_05;
    logic tmr_at_0;
    logic rev_cur;
    modport src (output vin_ok, vcc_ok, uv_en, ft_cmp, drain_cl_hi, drain_tmr_hi,
                 drain_pg_lo, in_limit, gate_above_th, gate_full, tmr_at_15,
                 tmr_at_075, tmr_at_05, tmr_at_0, rev_cur);
    modport dst (input vin_ok, vcc_ok, uv_en, ft_cmp, drain_cl_hi, drain_tmr_hi,
                 drain_pg_lo, in_limit, gate_above_th, gate_full, tmr_at_15,
                 tmr_at_075, tmr_at_05, tmr_at_0, rev_cur);
endinterface

// File: design/hs_cmp_sync.sv
// two-flop synchronisers for all comparator inputs
`timescale 1ns/1ps
module hs_cmp_sync #(
    parameter int N = 15
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // raw comparator levels
    input wire logic [N-1:0] raw,
    // synchronised levels
    hs_sync_if.src sy
);
    logic [N-1:0] meta_reg;
    logic [N-1:0] meta_next;
    logic [N-1:0] sync_reg;
    logic [N-1:0] sync_next;

    always_comb begin
        meta_next = raw;
        sync_next = meta_reg;
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sy.vin_ok = sync_reg[0];
    assign sy.vcc_ok = sync_reg[1];
    assign sy.uv_en = sync_reg[2];
    assign sy.ft_cmp = sync_reg[3];
    assign sy.drain_cl_hi = sync_reg[4];
    assign sy.drain_tmr_hi = sync_reg[5];
    assign sy.drain_pg_lo = sync_reg[6];
    assign sy.in_limit = sync_reg[7];
    assign sy.gate_above_th = sync_reg[8];
    assign sy.gate_full = sync_reg[9];
    assign sy.tmr_at_15 = sync_reg[10];
    assign sy.tmr_at_075 = sync_reg[11];
    assign sy.tmr_at_05 = sync_reg[12];
    assign sy.tmr_at_0 = sync_reg[13];
    assign sy.rev_cur = sync_reg[14];
endmodule // hs_cmp_sync

// File: design/hot_swap_fault_sequencer.sv
// hot swap controller: state machine, fault timer, gate and soft-start control
//
// Behaviour
// R1 - high current limit at low drain voltage, low limit at high drain voltage
// R2 - fast comparator pulls main gate low on overcurrent near twice the high limit
// R3 - limit select decodes to 24.5/40 mV limit with 2x or 3x fast trip
// R4 - in hot plug and insertion delay, soft-start open and discharged
// R5 - in start-up, soft-start node joined to the main gate
// R6 - in normal operation, soft-start neither joined nor grounded
// R7 - timer sinks small current when not in current limit
// R8 - in limit with gate above threshold, source 10 or 50 by drain level
// R9 - timeout at 1.5 V with low drain, 0.75 V with high drain
// R10 - cool-down: 63 cycles of discharge to 0.5 V and recharge, then full discharge
// R11 - enable toggled in cool-down: finish all cycles, then restart at once
// R12 - power-on with timer below 0.5 V starts directly, else full cool-down
// R13 - auxiliary gate on only while main gate on and fully enhanced, start-up included; off on shorts
// R14 - ORing gate switched off fast on reverse current
// R15 - input valid low on overvoltage, undervoltage or supply lockout
// R16 - fault-expired set on timeout, held through restart cycles, cleared after
// R17 - fast trip high whenever extreme overcurrent detected
// R18 - raw power good needs main gate, auxiliary gate and drain below 0.75 V
// R19 - filtered power good steers states and drives open-drain power good
// R20 - insertion done asserts once the insertion delay has elapsed
// R21 - four states: off, insertion delay, start-up, normal
// R22 - insertion delay goes to start-up when done, off on invalid input
// R23 - start-up to normal on filtered power good; off on fault or trip
// R24 - normal: overvoltage, undervoltage or trip only drops gate; lost good, timeout, supply lockout go off
// R25 - start-up uses low limit and low trip; normal follows drain level
// R26 - all comparator inputs synchronised before use
`timescale 1ns/1ps
module hot_swap_fault_sequencer
    import hs_pkg::*;
#(
    parameter int INS_CYC = INS_DELAY_CYC,
    parameter int PGR_CYC = PG_RISE_CYC,
    parameter int PGF_CYC = PG_FALL_CYC,
    parameter int COOL_N = COOL_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // supply and input comparators
    input wire logic overvoltage_input,
    input wire logic undervoltage_enable,
    input wire logic vcc_ok,
    // current sense comparators
    input wire logic fast_trip_cmp,
    input wire logic in_current_limit,
    input wire logic [1:0] limit_select_pin,
    // drain and gate sense
    input wire logic drain_above_cl_sw,
    input wire logic drain_above_tmr_sw,
    input wire logic drain_below_pg,
    input wire logic gate_above_th,
    input wire logic gate_fully_on,
    // timer capacitor comparators
    input wire logic tmr_at_1v5,
    input wire logic tmr_at_0v75,
    input wire logic tmr_at_0v5,
    input wire logic tmr_at_0v,
    // oring sense
    input wire logic reverse_current,
    // gate drivers
    output logic main_gate_en,
    output logic aux_fet_drive,
    output logic oring_fet_drive,
    // soft start switches
    output logic ss_to_gate,
    output logic ss_discharge,
    // current limit selection
    output logic high_current_limit,
    output logic low_current_limit,
    output logic limit_40mv,
    output logic fast_trip_3x,
    // timer current source
    output logic [1:0] tmr_current,
    // status
    output logic input_valid,
    output logic fault_expired,
    output logic insertion_done,
    output logic fast_trip,
    output logic power_good_raw,
    output logic power_good_filtered,
    output logic [1:0] hs_state,
    // open-drain power good, low means good
    output logic power_good_n_out_o,
    output logic power_good_n_out_oe
);
    hs_sync_if sy();

    hs_cmp_sync #(.N(15)) u_sync ( // [R26]
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .raw({reverse_current, tmr_at_0v, tmr_at_0v5, tmr_at_0v75, tmr_at_1v5,
              gate_fully_on, gate_above_th, in_current_limit, drain_below_pg,
              drain_above_tmr_sw, drain_above_cl_sw, fast_trip_cmp,
              undervoltage_enable, vcc_ok, ~overvoltage_input}),
        .sy(sy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registers
    hs_state_e st_reg, st_next;
    tmr_state_e ts_reg, ts_next;
    logic [5:0] cool_reg, cool_next;
    logic [CNT_W-1:0] ins_reg, ins_next;
    logic [CNT_W-1:0] pgc_reg, pgc_next;
    logic [2:0] por_reg, por_next;
    logic uv_prev_reg, uv_prev_next;
    logic restart_reg, restart_next;
    logic main_reg, main_next;
    logic aux_reg, aux_next;
    logic oring_reg, oring_next;
    logic ssg_reg, ssg_next;
    logic ssd_reg, ssd_next;
    logic hcl_reg, hcl_next;
    logic l40_reg, l40_next;
    logic ft3_reg, ft3_next;
    logic [1:0] ti_reg, ti_next;
    logic vld_reg, vld_next;
    logic to_reg, to_next;
    logic ins_done_reg, ins_done_next;
    logic ft_reg, ft_next;
    logic pgr_reg, pgr_next;
    logic pgf_reg, pgf_next;
    logic timeout_hit;
    logic valid_now;

    ////////////////////////////////////////////////////////////////////////////
    // combinational next state
    always_comb begin
        st_next = st_reg;
        ts_next = ts_reg;
        cool_next = cool_reg;
        ins_next = ins_reg;
        pgc_next = pgc_reg;
        por_next = {por_reg[1:0], 1'b0};
        uv_prev_next = sy.uv_en;
        restart_next = restart_reg;
        valid_now = sy.vin_ok && sy.uv_en && sy.vcc_ok; // [R15]
        vld_next = valid_now;
        ft_next = sy.ft_cmp; // [R17]
        // low drain gives 1.5 V limit, high drain 0.75 V
        timeout_hit = (st_reg == ST_START || st_reg == ST_NORMAL) && sy.in_limit &&
            (sy.drain_tmr_hi ? sy.tmr_at_075 : sy.tmr_at_15); // [R9]

        // enable toggled while cooling: remember it and restart anyway
        if (ts_reg != TMR_IDLE && (sy.uv_en != uv_prev_reg)) begin
            restart_next = 1'b1; // [R11]
        end

        // fault timer sequence
        case (ts_reg)
            TMR_IDLE: begin
                if (por_reg != 3'h0) begin
                    if (por_reg == 3'h4 && sy.tmr_at_05) begin // [R12]
                        ts_next = TMR_DISCH;
                        cool_next = COOL_RESET;
                    end
                end else if (timeout_hit) begin
                    ts_next = TMR_DISCH; // [R10]
                    cool_next = COOL_RESET;
                end
            end
            TMR_DISCH: begin
                if (!sy.tmr_at_05) begin
                    ts_next = TMR_CHARGE; // [R10]
                end
            end
            TMR_CHARGE: begin
                if (sy.tmr_at_15) begin
                    if (cool_reg == 6'(COOL_N - 1)) begin
                        ts_next = TMR_FINAL; // [R10]
                    end else begin
                        cool_next = cool_reg + 6'h01;
                        ts_next = TMR_DISCH;
                    end
                end
            end
            TMR_FINAL: begin
                if (sy.tmr_at_0) begin
                    ts_next = TMR_IDLE;
                end
            end
            default: ts_next = TMR_IDLE;
        endcase
        to_next = (ts_next != TMR_IDLE); // [R16]

        // timer current selection
        case (ts_next)
            TMR_DISCH: ti_next = TI_SINK2;
            TMR_CHARGE: ti_next = TI_SRC10;
            TMR_FINAL: ti_next = TI_FULL_DISCH;
            default: begin
                if (sy.in_limit && sy.gate_above_th) begin
                    ti_next = sy.drain_cl_hi ? TI_SRC50 : TI_SRC10; // [R8]
                end else begin
                    ti_next = TI_SINK2; // [R7]
                end
            end
        endcase

        // power good deglitch: 1 ms to rise, 32 ms to fall
        pgr_next = main_reg && aux_reg && sy.drain_pg_lo && valid_now
            && !sy.ft_cmp; // [R18] [R24]
        pgf_next = pgf_reg;
        if (pgr_reg == pgf_reg) begin
            pgc_next = '0;
        end else if (pgc_reg >= CNT_W'(pgf_reg ? PGF_CYC - 1 : PGR_CYC - 1)) begin
            pgf_next = pgr_reg; // [R19]
            pgc_next = '0;
        end else begin
            pgc_next = pgc_reg + 1'b1;
        end

        // insertion delay counter
        ins_done_next = 1'b0;
        if (st_reg == ST_INSERT) begin
            if (ins_reg >= CNT_W'(INS_CYC - 1)) begin
                ins_done_next = 1'b1; // [R20]
            end else begin
                ins_next = ins_reg + 1'b1;
            end
        end else begin
            ins_next = '0;
        end

        // main state machine
        case (st_reg) // [R21]
            ST_OFF: begin
                if (valid_now && ts_reg == TMR_IDLE && !to_reg && por_reg == 3'h0) begin
                    st_next = restart_reg ? ST_START : ST_INSERT; // [R11]
                    restart_next = 1'b0;
                end
            end
            ST_INSERT: begin
                if (!valid_now) begin
                    st_next = ST_OFF; // [R22]
                end else if (ins_done_reg) begin
                    st_next = ST_START; // [R22]
                end
            end
            ST_START: begin
                if (!valid_now || timeout_hit || sy.ft_cmp) begin
                    st_next = ST_OFF; // [R23]
                end else if (pgf_reg) begin
                    st_next = ST_NORMAL; // [R23]
                end
            end
            ST_NORMAL: begin
                if (!pgf_reg || timeout_hit || !sy.vcc_ok) begin
                    st_next = ST_OFF; // [R24]
                end
            end
            default: st_next = ST_OFF;
        endcase

        // gate, soft-start and limit drive from next state
        main_next = (st_next == ST_START || st_next == ST_NORMAL) && valid_now
            && !sy.ft_cmp && !timeout_hit; // [R2] [R24]
        aux_next = main_next && sy.gate_full; // [R13]
        oring_next = sy.vcc_ok && !sy.rev_cur; // [R14]
        ssg_next = (st_next == ST_START); // [R5]
        ssd_next = (st_next == ST_OFF || st_next == ST_INSERT); // [R4] [R6]
        // start-up forces low limit; normal follows drain
        hcl_next = (st_next == ST_NORMAL) && !sy.drain_cl_hi; // [R1] [R25]
        l40_next = (limit_select_pin == LIMIT_SELECT_PIN_R70K) ||
            (limit_select_pin == LIMIT_SELECT_PIN_GND); // [R3]
        ft3_next = (st_next == ST_NORMAL) && ((limit_select_pin == LIMIT_SELECT_PIN_R190K) ||
            (limit_select_pin == LIMIT_SELECT_PIN_R70K)); // [R3] [R25]
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers; por shifts out over the sync depth, cap judged on its last cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= ST_OFF;
            ts_reg <= TMR_IDLE;
            cool_reg <= COOL_RESET;
            ins_reg <= '0;
            pgc_reg <= '0;
            por_reg <= 3'h7;
            uv_prev_reg <= 1'b0;
            restart_reg <= 1'b0;
            main_reg <= 1'b0;
            aux_reg <= 1'b0;
            oring_reg <= 1'b0;
            ssg_reg <= 1'b0;
            ssd_reg <= 1'b1;
            hcl_reg <= 1'b0;
            l40_reg <= 1'b0;
            ft3_reg <= 1'b0;
            ti_reg <= TI_SINK2;
            vld_reg <= 1'b0;
            to_reg <= 1'b0;
            ins_done_reg <= 1'b0;
            ft_reg <= 1'b0;
            pgr_reg <= 1'b0;
            pgf_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            ts_reg <= ts_next;
            cool_reg <= cool_next;
            ins_reg <= ins_next;
            pgc_reg <= pgc_next;
            por_reg <= por_next;
            uv_prev_reg <= uv_prev_next;
            restart_reg <= restart_next;
            main_reg <= main_next;
            aux_reg <= aux_next;
            oring_reg <= oring_next;
            ssg_reg <= ssg_next;
            ssd_reg <= ssd_next;
            hcl_reg <= hcl_next;
            l40_reg <= l40_next;
            ft3_reg <= ft3_next;
            ti_reg <= ti_next;
            vld_reg <= vld_next;
            to_reg <= to_next;
            ins_done_reg <= ins_done_next;
            ft_reg <= ft_next;
            pgr_reg <= pgr_next;
            pgf_reg <= pgf_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops; power good pin level tied low
    assign main_gate_en = main_reg;
    assign aux_fet_drive = aux_reg;
    assign oring_fet_drive = oring_reg;
    assign ss_to_gate = ssg_reg;
    assign ss_discharge = ssd_reg;
    assign high_current_limit = hcl_reg;
    assign low_current_limit = ~hcl_reg;
    assign limit_40mv = l40_reg;
    assign fast_trip_3x = ft3_reg;
    assign tmr_current = ti_reg;
    assign input_valid = vld_reg;
    assign fault_expired = to_reg;
    assign insertion_done = ins_done_reg;
    assign fast_trip = ft_reg;
    assign power_good_raw = pgr_reg;
    assign power_good_filtered = pgf_reg;
    assign hs_state = st_reg;
    // pin pulled low while good; released otherwise
    assign power_good_n_out_o = 1'b0;
    assign power_good_n_out_oe = pgf_reg; // [R19]
endmodule // hot_swap_fault_sequencer

// File: test/hs_seq_sva.sv
// assertion checker for the hot swap fault sequencer ports
`timescale 1ns/1ps
module hs_seq_sva
    import hs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // watched inputs
    input wire logic overvoltage_input,
    input wire logic fast_trip_cmp,
    input wire logic reverse_current,
    // watched outputs
    input wire logic main_gate_en,
    input wire logic aux_fet_drive,
    input wire logic oring_fet_drive,
    input wire logic ss_to_gate,
    input wire logic ss_discharge,
    input wire logic high_current_limit,
    input wire logic low_current_limit,
    input wire logic [1:0] tmr_current,
    input wire logic input_valid,
    input wire logic fault_expired,
    input wire logic power_good_filtered,
    input wire logic [1:0] hs_state,
    input wire logic power_good_n_out_o,
    input wire logic power_good_n_out_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // three cycles of input sync and output register
    trip_gate_a: assert property (fast_trip_cmp |-> ##3 !main_gate_en)
        else $error("main gate still on after fast trip");
    rev_oring_a: assert property (reverse_current |-> ##3 !oring_fet_drive)
        else $error("oring gate still on after reverse current");
    ov_valid_a: assert property (overvoltage_input |-> ##3 !input_valid)
        else $error("input valid while overvoltage");
    ss_start_a: assert property (hs_state == ST_START |-> ss_to_gate && !ss_discharge)
        else $error("soft start not joined in start-up");
    ss_idle_a: assert property (hs_state inside {ST_OFF, ST_INSERT}
        |-> !ss_to_gate && ss_discharge)
        else $error("soft start not discharged while off");
    ss_norm_a: assert property (hs_state == ST_NORMAL |-> !ss_to_gate && !ss_discharge)
        else $error("soft start touched in normal");
    aux_main_a: assert property (aux_fet_drive |-> main_gate_en)
        else $error("aux gate on without main gate");
    limit_pair_a: assert property (low_current_limit == !high_current_limit)
        else $error("both or neither current limit selected");
    fault_off_a: assert property ($rose(fault_expired) |-> hs_state == ST_OFF)
        else $error("fault expired outside off state");
    pg_pin_a: assert property (power_good_n_out_oe == power_good_filtered
        && !power_good_n_out_o)
        else $error("power good pin disagrees with filtered good");
    start_c: cover property (hs_state == ST_START);
    fault_c: cover property ($rose(fault_expired));
    src50_c: cover property (tmr_current == TI_SRC50);
    normal_c: cover property (hs_state == ST_NORMAL);
endmodule // hs_seq_sva

// File: test/hs_far_side_model.sv
// model of external fets and timer capacitor
`timescale 1ns/1ps
module hs_far_side_model
    import hs_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // from the controller
    input wire logic main_gate_en,
    input wire logic [1:0] tmr_current,
    // sense levels back
    output logic gate_above_th,
    output logic gate_fully_on,
    output logic tmr_at_1v5,
    output logic tmr_at_0v75,
    output logic tmr_at_0v5,
    output logic tmr_at_0v
);
    // cap level in steps, 15 = 1.5 V; the cap keeps charge over reset
    int level = 0;
    always @(posedge clk_sys) begin
        gate_above_th <= main_gate_en;
        gate_fully_on <= main_gate_en;
        case (tmr_current)
            TI_SINK2: level <= (level > 0) ? level - 1 : 0;
            TI_SRC10: level <= (level < 20) ? level + 1 : 20;
            TI_SRC50: level <= (level < 19) ? level + 2 : 20;
            default: level <= (level > 4) ? level - 4 : 0;
        endcase
    end
    assign tmr_at_1v5 = (level >= 15);
    assign tmr_at_0v75 = (level >= 8);
    assign tmr_at_0v5 = (level >= 5);
    assign tmr_at_0v = (level == 0);
endmodule // hs_far_side_model

// File: test/hot_swap_fault_sequencer_tb_top.sv
// self-checking testbench for the hot swap fault sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, e); end end
module hot_swap_fault_sequencer_tb_top;
    import hs_pkg::*;
    logic clk_sys = 0, rst_b = 0, ov = 0, uv_en = 1, vcc_ok = 1, ft = 0, in_lim = 0;
    logic cl_sw = 0, tmr_sw = 0, pg_lo = 1, rev = 0;
    logic [1:0] strap = 2'h0;
    logic gate_th, gate_full, t15, t075, t05, t0;
    logic main_gate_en, aux_fet_drive, oring_fet_drive, ss_to_gate, ss_discharge;
    logic high_current_limit, low_current_limit, limit_40mv, fast_trip_3x;
    logic input_valid, fault_expired, fast_trip, power_good_filtered, insertion_done, power_good_raw;
    logic [1:0] tmr_current, hs_state;
    int n_mismatch = 0, tests_run = 0, cnt, i;
    logic [1:0] prev;
    logic full;
    always #10 clk_sys = ~clk_sys;
    hot_swap_fault_sequencer #(.INS_CYC(8), .PGR_CYC(4), .PGF_CYC(8), .COOL_N(63)) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .overvoltage_input(ov),
        .undervoltage_enable(uv_en), .vcc_ok(vcc_ok), .fast_trip_cmp(ft),
        .in_current_limit(in_lim), .limit_select_pin(strap), .drain_above_cl_sw(cl_sw),
        .drain_above_tmr_sw(tmr_sw), .drain_below_pg(pg_lo), .gate_above_th(gate_th),
        .gate_fully_on(gate_full), .tmr_at_1v5(t15), .tmr_at_0v75(t075), .tmr_at_0v5(t05),
        .tmr_at_0v(t0), .reverse_current(rev), .main_gate_en(main_gate_en),
        .aux_fet_drive(aux_fet_drive), .oring_fet_drive(oring_fet_drive),
        .ss_to_gate(ss_to_gate), .ss_discharge(ss_discharge),
        .high_current_limit(high_current_limit), .low_current_limit(low_current_limit),
        .limit_40mv(limit_40mv), .fast_trip_3x(fast_trip_3x), .tmr_current(tmr_current),
        .input_valid(input_valid), .fault_expired(fault_expired),
        .insertion_done(insertion_done), .fast_trip(fast_trip),
        .power_good_raw(power_good_raw), .power_good_filtered(power_good_filtered),
        .hs_state(hs_state), .power_good_n_out_o(), .power_good_n_out_oe());
    hs_far_side_model i_far (.clk_sys(clk_sys), .main_gate_en(main_gate_en),
        .tmr_current(tmr_current), .gate_above_th(gate_th), .gate_fully_on(gate_full),
        .tmr_at_1v5(t15), .tmr_at_0v75(t075), .tmr_at_0v5(t05), .tmr_at_0v(t0));
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wait_st(input logic [1:0] s, input int n);
        int k;
        k = 0;
        while (hs_state !== s && k < n) begin
            @(negedge clk_sys);
            k++;
        end
        if (hs_state !== s) begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h expected %0h", $time, hs_state, s);
            results();
        end
    endtask
    task automatic do_reset();
        rst_b = 0;
        repeat (12) @(negedge clk_sys);
        rst_b = 1;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        // each strap code from a fresh reset; empty timer starts directly
        for (int k = 0; k < 4; k++) begin
            strap = k[1:0];
            do_reset();
            `CHK(ss_discharge, 1'b1)
            wait_st(ST_START, 60);
            `CHK(insertion_done, 1'b1)
            ticks(2);
            `CHK(limit_40mv, strap[1])
            `CHK(fast_trip_3x, 1'b0)
            `CHK(low_current_limit, 1'b1)
            `CHK(main_gate_en, 1'b1)
            `CHK(aux_fet_drive, 1'b0)
        end
        // current limit drives timer sourcing, then timeout
        in_lim = 1;
        ticks(6);
        `CHK(tmr_current, 2'(TI_SRC10))
        wait_st(ST_NORMAL, 20);
        `CHK(aux_fet_drive, 1'b1)
        `CHK(power_good_raw, 1'b1)
        `CHK(power_good_filtered, 1'b1)
        `CHK(ss_discharge, 1'b0)
        `CHK(high_current_limit, 1'b1)
        cl_sw = 1;
        ticks(4);
        `CHK(tmr_current, 2'(TI_SRC50))
        `CHK(high_current_limit, 1'b0)
        wait_st(ST_OFF, 60);
        ticks(1);
        `CHK(fault_expired, 1'b1)
        `CHK(main_gate_en, 1'b0)
        in_lim = 0;
        cl_sw = 0;
        // brief reset with the cap still charged: power-on must run the cool-down
        rst_b = 0;
        ticks(1);
        rst_b = 1;
        ticks(4);
        `CHK(fault_expired, 1'b1)
        `CHK(hs_state, 2'(ST_OFF))
        // enable toggled early in cool-down
        uv_en = 0;
        ticks(10);
        uv_en = 1;
        cnt = 0;
        i = 0;
        full = 0;
        prev = tmr_current;
        while (fault_expired === 1'b1 && i < 20000) begin
            @(negedge clk_sys);
            if (tmr_current === 2'h1 && prev !== 2'h1) cnt++;
            if (tmr_current === 2'h3) full = 1;
            prev = tmr_current;
            i++;
        end
        `CHK(cnt, 63)
        `CHK(full, 1'b1)
        `CHK(fault_expired, 1'b0)
        if (fault_expired !== 1'b0) results();
        wait_st(ST_START, 3);
        ticks(4);
        `CHK(tmr_current, 2'(TI_SINK2))
        // fast trip in start-up
        ft = 1;
        wait_st(ST_OFF, 10);
        `CHK(fast_trip, 1'b1)
        ft = 0;
        // overvoltage during insertion delay
        wait_st(ST_INSERT, 40);
        ov = 1;
        wait_st(ST_OFF, 10);
        `CHK(input_valid, 1'b0)
        ov = 0;
        wait_st(ST_START, 60);
        rev = 1;
        ticks(4);
        `CHK(oring_fet_drive, 1'b0)
        rev = 0;
        ticks(4);
        results();
    end
endmodule // hot_swap_fault_sequencer_tb_top
bind hot_swap_fault_sequencer hs_seq_sva i_sva (.clk_sys(clk_sys), .rst_b(rst_b),
    .overvoltage_input(overvoltage_input), .fast_trip_cmp(fast_trip_cmp),
    .reverse_current(reverse_current), .main_gate_en(main_gate_en),
    .aux_fet_drive(aux_fet_drive), .oring_fet_drive(oring_fet_drive),
    .ss_to_gate(ss_to_gate), .ss_discharge(ss_discharge),
    .high_current_limit(high_current_limit), .low_current_limit(low_current_limit),
    .tmr_current(tmr_current), .input_valid(input_valid), .fault_expired(fault_expired),
    .power_good_filtered(power_good_filtered), .hs_state(hs_state),
    .power_good_n_out_o(power_good_n_out_o), .power_good_n_out_oe(power_good_n_out_oe));
